/* File: bench/cab_tb.sv */
// self-checking bench for cab_core: register port tasks, instruction issue
// assumes one clock; the data memory is modelled here, answering one clk late
`timescale 1ns/1ns
module tb;
  import cab_pkg::*;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t got %h expected %h", $time, a, b); end end

  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic [15:0] instr_word  = 16'h0000;
  logic        instr_valid = 1'b0;
  logic [3:0]  reg_addr    = 4'h0;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [7:0]  mem_rdata   = 8'h00;
  logic [1:0]  ph          = 2'h0;
  logic        trail       = 1'b0;
  logic [7:0]  reg_rdata, mem_wdata, rv, wr_d, pv;
  logic [11:0] mem_addr, rd_a, wr_a;
  logic        mem_rd, mem_wr, cycle_done, flush_active;
  logic [20:0] pc_out, pc0, tgt;
  logic [1:0]  rd_ph, wr_ph;
  logic [7:0]  mem [0:4095];
  logic [7:0]  offs [3] = '{8'h05, 8'h7F, 8'h80};
  int          mismatches  = 0;
  int          comparisons = 0;

  always #2 clk = ~clk;

  cab_core u_cab_core (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
    .instr_valid(instr_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .pc_out(pc_out), .cycle_done(cycle_done), .flush_active(flush_active));

  // phase count rebased on cycle_done; idle read data toggles so stale bytes show
  always @(posedge clk) begin
    ph <= cycle_done ? 2'h0 : ph + 2'h1;
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_rd) begin
      rd_a <= mem_addr;
      rd_ph <= ph;
    end
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      wr_a <= mem_addr;
      wr_d <= mem_wdata;
      wr_ph <= ph;
    end
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic done_t(input string s);
    $display("test %0s done at %0t", s, $time);
  endtask : done_t

  // idle clk after each strobe so no task re-raises it in the same step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
    @(posedge clk);
  endtask : rd

  // ends on the edge that closes a Q4
  task automatic sync;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (cycle_done !== 1'b1 && i < 8);
    `CHK(cycle_done, 1'b1)
    @(posedge clk);
  endtask : sync

  task automatic exec(input logic [15:0] w);
    sync();
    instr_word <= w;
    instr_valid <= 1'b1;
    @(negedge clk);
    pc0 = pc_out;
    sync();
    instr_word <= 16'h0B00;
    instr_valid <= trail;
  endtask : exec

  task automatic prep(input logic [7:0] b, w, s, c);
    wr(CAB_REG_BANK, b);
    wr(CAB_REG_W, w);
    wr(CAB_REG_STATUS, s);
    wr(CAB_REG_CTRL, c);
  endtask : prep

  task automatic chkws(input logic [7:0] ew, input logic [4:0] es);
    rd(CAB_REG_W);
    `CHK(rv, ew)
    rd(CAB_REG_STATUS);
    `CHK(rv[4:0], es)
  endtask : chkws

  task automatic fop(input logic [15:0] w, input logic [11:0] ea,
                     input logic [7:0] em, ew, input logic [4:0] es);
    exec(w);
    @(negedge clk);
    `CHK(rd_a, ea)
    `CHK(rd_ph, 2'h1)
    `CHK(mem[ea], em)
    @(posedge clk);
    chkws(ew, es);
  endtask : fop

  initial begin
    #20000;
    mismatches++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    prep(8'h03, 8'h4D, 8'h01, 8'h00);
    mem[12'h310] = 8'h02;
    fop(16'h2110, 12'h310, 8'h02, 8'h50, 5'h02);
    prep(8'h03, 8'h7F, 8'h00, 8'h00);
    mem[12'hF70] = 8'h01;
    fop(16'h2270, 12'hF70, 8'h80, 8'h7F, 5'h1A);
    prep(8'h03, 8'hFF, 8'h01, 8'h00);
    mem[12'h05F] = 8'h00;
    fop(16'h205F, 12'h05F, 8'h00, 8'h00, 5'h07);
    done_t("add with carry");
    // index base near the top, so the sum must wrap
    wr(CAB_REG_IDX_L, 8'hFE);
    wr(CAB_REG_IDX_H, 8'h0F);
    prep(8'h03, 8'hF0, 8'h0B, 8'h01);
    mem[12'h003] = 8'h3C;
    fop(16'h1405, 12'h003, 8'h3C, 8'h30, 5'h0B);
    mem[12'h05D] = 8'h0F;
    fop(16'h165F, 12'h05D, 8'h00, 8'h30, 5'h0F);
    mem[12'hF60] = 8'hF0;
    fop(16'h1460, 12'hF60, 8'hF0, 8'h30, 5'h0B);
    mem[12'h305] = 8'hA0;
    fop(16'h1505, 12'h305, 8'hA0, 8'h20, 5'h0B);
    done_t("and with file");
    prep(8'h03, 8'hA3, 8'h1F, 8'h00);
    exec(16'h0B5F);
    chkws(8'h03, 5'h0B);
    exec(16'h0BF0);
    chkws(8'h00, 5'h0F);
    done_t("and literal");
    // an and-literal is offered in the flush cycle; it must not land
    foreach (offs[i]) begin
      prep(8'h03, 8'h11, 8'h1F, 8'h00);
      trail = 1'b1;
      exec({CAB_ENC_BRC, offs[i]});
      trail = 1'b0;
      tgt = pc0 + 21'h000002 + {{12{offs[i][7]}}, offs[i], 1'b0};
      @(negedge clk);
      `CHK(flush_active, 1'b1)
      `CHK(pc_out, tgt)
      sync();
      instr_valid <= 1'b0;
      @(negedge clk);
      `CHK(flush_active, 1'b0)
      `CHK(pc_out, tgt)
      @(posedge clk);
      chkws(8'h11, 5'h1F);
    end
    prep(8'h03, 8'h11, 8'h1E, 8'h00);
    exec(16'hE2F0);
    @(negedge clk);
    `CHK(flush_active, 1'b0)
    `CHK(pc_out, pc0 + 21'h000002)
    @(posedge clk);
    chkws(8'h11, 5'h1E);
    done_t("branch on carry");
    for (int b = 0; b < 8; b++) begin
      prep(8'h03, 8'h11, 8'h15, 8'h00);
      pv = 8'hC7 + 8'(b * 17);
      mem[12'h322] = pv;
      exec({CAB_ENC_BCLR, 3'(b), 1'b1, 8'h22});
      @(negedge clk);
      `CHK(wr_a, 12'h322)
      `CHK(wr_d, pv & ~(8'h01 << b))
      `CHK(rd_ph, 2'h1)
      `CHK(wr_ph, 2'h3)
      @(posedge clk);
      chkws(8'h11, 5'h15);
    end
    done_t("bit clear");
    // undecoded word runs as a nop and raises the sticky flag
    exec(16'hFFFF);
    rd(CAB_REG_STATE);
    `CHK(rv[3:2], 2'b01)
    wr(CAB_REG_STATE, 8'h04);
    rd(CAB_REG_STATE);
    `CHK(rv[3:2], 2'b00)
    done_t("illegal word");
    results();
  end

endmodule : tb

/* File: core/cab_alu.sv */
// arithmetic and logic for the execution slice, purely combinational
// assumes operand already chosen (file byte or literal) by the caller
`timescale 1ns/1ns
module cab_alu
  import cab_pkg::*;
(
  input  wire cab_op_type op,
  input  wire logic [7:0] w,
  input  wire logic [7:0] opnd,
  input  wire logic       carry,
  input  wire logic [2:0] bsel,
  output logic [7:0]      res,
  output logic [4:0]      fl,
  output logic [4:0]      fl_mask
);

  logic [8:0] sum9;
  logic [4:0] half5;

  always_comb begin
    sum9    = {1'b0, w} + {1'b0, opnd} + {8'h00, carry}; // RULE1
    half5   = {1'b0, w[3:0]} + {1'b0, opnd[3:0]} + {4'h0, carry};
    res     = 8'h00;
    fl      = 5'h00;
    fl_mask = 5'h00;
    case (op)
      CAB_OP_ADD_WITH_CARRY_TO_FILE: begin
        res              = sum9[7:0]; // RULE1
        fl[CAB_ST_C]     = sum9[8]; // RULE13
        fl[CAB_ST_HC]    = half5[4]; // RULE13
        fl[CAB_ST_SRE]   = (w[7] == opnd[7]) && (sum9[7] != w[7]); // RULE13
        fl[CAB_ST_N]     = sum9[7];
        fl[CAB_ST_Z]     = (sum9[7:0] == 8'h00);
        fl_mask          = 5'h1F; // RULE2
      end
      CAB_OP_AND_LITERAL_INTO_WORKING, CAB_OP_AND_WORKING_WITH_FILE: begin
        res           = w & opnd; // RULE6 RULE7
        fl[CAB_ST_N]  = res[7];
        fl[CAB_ST_Z]  = (res == 8'h00);
        fl_mask[CAB_ST_N] = 1'b1; // RULE6 RULE7
        fl_mask[CAB_ST_Z] = 1'b1;
      end
      CAB_OP_CLEAR_BIT_IN_FILE: begin
        // whole byte comes back; only the selected bit drops
        res = opnd & ~(8'h01 << bsel); // RULE12
      end
      default: begin
        res = opnd;
      end
    endcase
  end

endmodule : cab_alu

/* File: core/cab_core.sv */
// execution slice: decode, operand read, compute and write-back
// assumes a data memory answering a read one clk later, same clock
`timescale 1ns/1ns
module cab_core
  import cab_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [11:0] mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  output logic      [20:0] pc_out,
  output logic             cycle_done,
  output logic             flush_active
);

  cab_state_type s_reg;
  cab_state_type s_next;

  cab_op_type dec_op;
  logic [7:0] alu_opnd;
  logic [7:0] alu_res;
  logic [4:0] alu_fl;
  logic [4:0] alu_mask;
  logic [20:0] br_target;

  function automatic cab_op_type decode_op(input logic [15:0] iw);
    cab_op_type op;
    op = CAB_OP_NOP;
    if (iw[15:10] == CAB_ENC_ADDC) begin
      op = CAB_OP_ADD_WITH_CARRY_TO_FILE; // RULE1
    end else if (iw[15:8] == CAB_ENC_ANDL) begin
      op = CAB_OP_AND_LITERAL_INTO_WORKING; // RULE6
    end else if (iw[15:10] == CAB_ENC_ANDF) begin
      op = CAB_OP_AND_WORKING_WITH_FILE; // RULE7
    end else if (iw[15:8] == CAB_ENC_BRC) begin
      op = CAB_OP_BRANCH_ON_CARRY_SET; // RULE9
    end else if (iw[15:12] == CAB_ENC_BCLR) begin
      op = CAB_OP_CLEAR_BIT_IN_FILE; // RULE12
    end
    return op;
  endfunction : decode_op

  function automatic logic is_file_op(input cab_op_type op);
    return (op == CAB_OP_ADD_WITH_CARRY_TO_FILE) || (op == CAB_OP_AND_WORKING_WITH_FILE) ||
           (op == CAB_OP_CLEAR_BIT_IN_FILE);
  endfunction : is_file_op

  function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                            input logic [3:0] bank, input logic ext,
                                            input logic [11:0] idx);
    logic [11:0] ad;
    if (a) begin
      ad = {bank, f}; // RULE4
    end else if (ext && (f <= CAB_IDX_LIMIT)) begin
      ad = 12'(idx + {4'h0, f}); // RULE5
    end else if (f < CAB_ACC_SPLIT) begin
      ad = {CAB_ACC_LO_BANK, f}; // RULE4
    end else begin
      ad = {CAB_ACC_HI_BANK, f};
    end
    return ad;
  endfunction : file_addr

  function automatic logic [7:0] reg_read(input logic [3:0] addr, input cab_state_type s);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      CAB_REG_CTRL:   v[CAB_CTRL_EXT] = s.ext;
      CAB_REG_BANK:   v = {4'h0, s.bank};
      CAB_REG_W:      v = s.w;
      CAB_REG_STATUS: v = {3'h0, s.st};
      CAB_REG_PC_L:   v = s.pc[7:0];
      CAB_REG_PC_M:   v = s.pc[15:8];
      CAB_REG_PC_H:   v = {3'h0, s.pc[20:16]};
      CAB_REG_IDX_L:  v = s.idx[7:0];
      CAB_REG_IDX_H:  v = {4'h0, s.idx[11:8]};
      CAB_REG_STATE:  v = {4'h0, s.flush, s.illegal, s.q};
      default:        v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // literal operand only for the and-literal form
  assign alu_opnd = (s_reg.op == CAB_OP_AND_LITERAL_INTO_WORKING) ? s_reg.lit : mem_rdata;
  assign dec_op   = instr_valid ? decode_op(instr_word) : CAB_OP_NOP;
  // pc still holds the branch's own address here
  assign br_target = 21'(s_reg.pc + CAB_PC_STEP + {{12{s_reg.lit[7]}}, s_reg.lit, 1'b0}); // RULE10

  cab_alu u_alu (
    .op      (s_reg.op),
    .w       (s_reg.w),
    .opnd    (alu_opnd),
    .carry   (s_reg.st[CAB_ST_C]),
    .bsel    (s_reg.bsel),
    .res     (alu_res),
    .fl      (alu_fl),
    .fl_mask (alu_mask)
  );

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    s_next.rdat = 8'h00;
    if (reg_rd) begin
      s_next.rdat = reg_read(reg_addr, s_reg);
    end
    // software writes first; a core commit in the same clk overrides
    if (reg_wr) begin
      case (reg_addr)
        CAB_REG_CTRL:   s_next.ext = reg_wdata[CAB_CTRL_EXT];
        CAB_REG_BANK:   s_next.bank = reg_wdata[3:0];
        CAB_REG_W:      s_next.w = reg_wdata;
        CAB_REG_STATUS: s_next.st = reg_wdata[4:0];
        CAB_REG_PC_L:   s_next.pc[7:0] = reg_wdata;
        CAB_REG_PC_M:   s_next.pc[15:8] = reg_wdata;
        CAB_REG_PC_H:   s_next.pc[20:16] = reg_wdata[4:0];
        CAB_REG_IDX_L:  s_next.idx[7:0] = reg_wdata;
        CAB_REG_IDX_H:  s_next.idx[11:8] = reg_wdata[3:0];
        CAB_REG_STATE: begin
          if (reg_wdata[CAB_STATE_ILL]) begin
            s_next.illegal = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    case (s_reg.q)
      CAB_Q1: begin
        s_next.q = CAB_Q2; // RULE8
        if (s_reg.flush) begin
          s_next.op = CAB_OP_NOP; // RULE11
        end else begin
          s_next.op = dec_op; // RULE8
          // set beats a same-clk software clear
          if (instr_valid && (dec_op == CAB_OP_NOP)) begin
            s_next.illegal = 1'b1;
          end
        end
        s_next.d     = instr_word[9]; // RULE3
        s_next.bsel  = instr_word[11:9];
        s_next.lit   = instr_word[7:0];
        s_next.maddr = file_addr(instr_word[8], instr_word[7:0], s_reg.bank, s_reg.ext,
                                 s_reg.idx); // RULE4 RULE5
        s_next.mrd   = !s_reg.flush && is_file_op(dec_op); // RULE8 RULE14
      end
      CAB_Q2: begin
        s_next.q   = CAB_Q3;
        s_next.mrd = 1'b0;
      end
      CAB_Q3: begin
        s_next.q      = CAB_Q4; // RULE8
        s_next.res    = alu_res;
        s_next.fl     = (s_reg.st & ~alu_mask) | (alu_fl & alu_mask); // RULE2 RULE9 RULE12
        s_next.mwdata = alu_res;
        s_next.mwr    = (s_reg.op == CAB_OP_CLEAR_BIT_IN_FILE) ||
                        (is_file_op(s_reg.op) && s_reg.d); // RULE3 RULE14
        s_next.taken  = (s_reg.op == CAB_OP_BRANCH_ON_CARRY_SET) && s_reg.st[CAB_ST_C]; // RULE9
        s_next.done   = 1'b1;
      end
      CAB_Q4: begin
        s_next.q     = CAB_Q1;
        s_next.mwr   = 1'b0;
        s_next.taken = 1'b0;
        if ((s_reg.op == CAB_OP_AND_LITERAL_INTO_WORKING) ||
            ((s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE) && !s_reg.d) ||
            ((s_reg.op == CAB_OP_AND_WORKING_WITH_FILE) && !s_reg.d)) begin
          s_next.w = s_reg.res; // RULE3 RULE6
        end
        if ((s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE) ||
            (s_reg.op == CAB_OP_AND_LITERAL_INTO_WORKING) ||
            (s_reg.op == CAB_OP_AND_WORKING_WITH_FILE)) begin
          s_next.st = s_reg.fl; // RULE2
        end
        if (s_reg.flush) begin
          // nop cycle after a jump: pc already points at the target
          s_next.flush = 1'b0; // RULE11
        end else if (s_reg.taken) begin
          s_next.pc    = br_target; // RULE10 RULE11
          s_next.flush = 1'b1; // RULE11
        end else begin
          s_next.pc = 21'(s_reg.pc + CAB_PC_STEP);
        end
      end
      default: begin
        s_next.q = CAB_Q1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg         <= '0;
      s_reg.q       <= CAB_Q1;
      s_reg.pc      <= CAB_PC_RST;
      s_reg.w       <= CAB_W_RST;
      s_reg.st      <= CAB_ST_RST;
      s_reg.bank    <= CAB_BANK_RST;
      s_reg.idx     <= CAB_IDX_RST;
      s_reg.op      <= CAB_OP_NOP;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata    = s_reg.rdat;
  assign mem_addr     = s_reg.maddr;
  assign mem_rd       = s_reg.mrd;
  assign mem_wr       = s_reg.mwr;
  assign mem_wdata    = s_reg.mwdata;
  assign pc_out       = s_reg.pc;
  assign cycle_done   = s_reg.done;
  assign flush_active = s_reg.flush;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  addc_sum_a: assert property ( // RULE1
    (s_reg.q == CAB_Q3 && s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE) |=>
      s_reg.res == $past(8'(s_reg.w + mem_rdata + {7'h00, s_reg.st[CAB_ST_C]})))
    else $error("add with carry result wrong");

  addc_flags_a: assert property ( // RULE2
    (s_reg.q == CAB_Q3 && s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE && !reg_wr) |=>
      ##1 (s_reg.st[CAB_ST_Z] == (s_reg.res == 8'h00)) && (s_reg.st[CAB_ST_N] == s_reg.res[7]))
    else $error("add with carry flags not committed");

  addc_carry_a: assert property ( // RULE13
    (s_reg.q == CAB_Q3 && s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE) |=>
      s_reg.fl[CAB_ST_C] == $past(({1'b0, s_reg.w} + {1'b0, mem_rdata}
        + {8'h00, s_reg.st[CAB_ST_C]}) > 9'h0FF))
    else $error("carry out of bit 7 wrong");

  dest_file_a: assert property ( // RULE3
    (s_reg.q == CAB_Q3 && s_reg.op == CAB_OP_AND_WORKING_WITH_FILE) |=>
      (mem_wr == s_reg.d) && (mem_wdata == s_reg.res))
    else $error("destination routing wrong");

  dest_work_a: assert property ( // RULE3
    (s_reg.q == CAB_Q4 && s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE && !s_reg.d) |=>
      s_reg.w == $past(s_reg.res) && !mem_wr)
    else $error("w not written for d of 0");

  bank_addr_a: assert property ( // RULE4
    (s_reg.q == CAB_Q1 && !s_reg.flush && instr_valid && instr_word[8] &&
     is_file_op(dec_op)) |=> mem_rd && mem_addr == {$past(s_reg.bank), $past(instr_word[7:0])})
    else $error("banked address wrong");

  idx_addr_a: assert property ( // RULE5
    (s_reg.q == CAB_Q1 && !s_reg.flush && s_reg.ext && !instr_word[8] &&
     instr_word[7:0] <= CAB_IDX_LIMIT) |=>
      mem_addr == $past(12'(s_reg.idx + {4'h0, instr_word[7:0]})))
    else $error("indexed literal offset address wrong");

  andl_flags_a: assert property ( // RULE6
    (s_reg.q == CAB_Q4 && s_reg.op == CAB_OP_AND_LITERAL_INTO_WORKING && !reg_wr) |=>
      $stable(s_reg.st[CAB_ST_C]) && $stable(s_reg.st[CAB_ST_HC]) &&
      $stable(s_reg.st[CAB_ST_SRE]) && s_reg.w == $past(s_reg.res))
    else $error("and literal touched other flags");

  read_phase_a: assert property ( // RULE8
    mem_rd |-> s_reg.q == CAB_Q2 ##1 !mem_rd ##1 s_reg.q == CAB_Q4)
    else $error("operand read outside phase 2");

  branch_flags_a: assert property ( // RULE9
    (s_reg.q == CAB_Q4 && s_reg.op == CAB_OP_BRANCH_ON_CARRY_SET && !reg_wr) |=>
      $stable(s_reg.st) && !mem_wr)
    else $error("branch changed status");

  branch_target_a: assert property ( // RULE10
    (s_reg.q == CAB_Q4 && s_reg.taken && !s_reg.flush) |=>
      pc_out == $past(21'(s_reg.pc + CAB_PC_STEP + {{12{s_reg.lit[7]}}, s_reg.lit, 1'b0})))
    else $error("branch target wrong");

  branch_nop_a: assert property ( // RULE11
    (s_reg.q == CAB_Q4 && s_reg.taken && !s_reg.flush) |=>
      flush_active ##1 (s_reg.op == CAB_OP_NOP && flush_active)[*3] ##1 !flush_active)
    else $error("taken branch missing nop cycle");

  untaken_step_a: assert property ( // RULE11
    (s_reg.q == CAB_Q4 && s_reg.op == CAB_OP_BRANCH_ON_CARRY_SET && !s_reg.taken &&
     !s_reg.flush) |=> !flush_active && pc_out == $past(21'(s_reg.pc + CAB_PC_STEP)))
    else $error("untaken branch not one cycle");

  andf_flags_a: assert property ( // RULE7
    (s_reg.q == CAB_Q4 && s_reg.op == CAB_OP_AND_WORKING_WITH_FILE && !reg_wr) |=>
      $stable(s_reg.st[CAB_ST_C]) && $stable(s_reg.st[CAB_ST_HC]) &&
      s_reg.st[CAB_ST_Z] == (s_reg.res == 8'h00) && s_reg.st[CAB_ST_N] == s_reg.res[7])
    else $error("and with file flags wrong");

  bclr_flags_a: assert property ( // RULE12
    (s_reg.q == CAB_Q4 && s_reg.op == CAB_OP_CLEAR_BIT_IN_FILE && !reg_wr) |=>
      $stable(s_reg.st) && $stable(s_reg.w))
    else $error("bit clear touched status or w");

  half_carry_a: assert property ( // RULE13
    (s_reg.q == CAB_Q3 && s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE) |=>
      s_reg.fl[CAB_ST_HC] == $past(({1'b0, s_reg.w[3:0]} + {1'b0, mem_rdata[3:0]}
        + {4'h0, s_reg.st[CAB_ST_C]}) > 5'h0F))
    else $error("half carry out of bit 3 wrong");

  write_phase_a: assert property ( // RULE8
    mem_wr |-> s_reg.q == CAB_Q4 && cycle_done ##1 !mem_wr)
    else $error("destination write outside phase 4");

  illegal_set_a: assert property ( // RULE8
    (s_reg.q == CAB_Q1 && !s_reg.flush && instr_valid && dec_op == CAB_OP_NOP) |=>
      s_reg.illegal)
    else $error("undecoded word not flagged");

  bclr_rmw_a: assert property ( // RULE12
    (s_reg.q == CAB_Q3 && s_reg.op == CAB_OP_CLEAR_BIT_IN_FILE) |=>
      mem_wr && mem_wdata == $past(mem_rdata & ~(8'h01 << s_reg.bsel)) &&
      mem_addr == $past(mem_addr) ##1 !mem_wr)
    else $error("bit clear write-back wrong");

  bclr_phase_a: assert property ( // RULE14
    (mem_rd && s_reg.op == CAB_OP_CLEAR_BIT_IN_FILE) |-> ##2 mem_wr && s_reg.q == CAB_Q4)
    else $error("bit clear not written in phase 4");

  addc_cov: cover property (
    s_reg.q == CAB_Q4 && s_reg.op == CAB_OP_ADD_WITH_CARRY_TO_FILE && s_reg.fl[CAB_ST_C]);
  branch_cov: cover property (
    s_reg.q == CAB_Q4 && s_reg.taken ##1 flush_active [*4]);
  bclr_cov: cover property (mem_wr && s_reg.op == CAB_OP_CLEAR_BIT_IN_FILE);
  idx_cov: cover property (s_reg.q == CAB_Q1 && s_reg.ext && !instr_word[8] && instr_valid);

endmodule : cab_core

/* File: core/cab_pkg.sv */
// constants, opcode patterns, op enumeration and state record for the
// add/and/branch/bit-clear execution slice; assumes a 4-clk instruction cycle
// Overview of operation
// [RULE1] add with carry sums w, file, carry
// [RULE2] add with carry updates n, ov, c, dc, z
// [RULE3] destination bit: 0 to w, 1 to file
// [RULE4] bank bit: access bank or bank register
// [RULE5] extended mode, f<=5Fh: indexed literal offset
// [RULE6] and literal: w and k, n z only
// [RULE7] and with file: route by d, n z
// [RULE8] phases: decode, read, compute, write
// [RULE9] branch on carry set, flags untouched
// [RULE10] taken target is address plus 2 plus 2n
// [RULE11] taken branch adds one full nop cycle
// [RULE12] bit clear b of file, no flags
// [RULE13] c bit7 carry, dc bit3, signed overflow
// [RULE14] bit clear is read-modify-write, same cycle
package cab_pkg;

  // register port offsets
  localparam logic [3:0] CAB_REG_CTRL   = 4'h0;
  localparam logic [3:0] CAB_REG_BANK   = 4'h1;
  localparam logic [3:0] CAB_REG_W      = 4'h2;
  localparam logic [3:0] CAB_REG_STATUS = 4'h3;
  localparam logic [3:0] CAB_REG_PC_L   = 4'h4;
  localparam logic [3:0] CAB_REG_PC_M   = 4'h5;
  localparam logic [3:0] CAB_REG_PC_H   = 4'h6;
  localparam logic [3:0] CAB_REG_IDX_L  = 4'h7;
  localparam logic [3:0] CAB_REG_IDX_H  = 4'h8;
  localparam logic [3:0] CAB_REG_STATE  = 4'h9;

  // field positions
  localparam int CAB_CTRL_EXT  = 0;
  localparam int CAB_STATE_ILL = 2;
  localparam int CAB_STATE_FL  = 3;
  localparam int CAB_ST_C      = 0;
  localparam int CAB_ST_HC     = 1;
  localparam int CAB_ST_Z      = 2;
  localparam int CAB_ST_SRE    = 3;
  localparam int CAB_ST_N      = 4;

  // reset values
  localparam logic [20:0] CAB_PC_RST  = 21'h000000;
  localparam logic [7:0]  CAB_W_RST   = 8'h00;
  localparam logic [4:0]  CAB_ST_RST  = 5'h00;
  localparam logic [3:0]  CAB_BANK_RST = 4'h0;
  localparam logic [11:0] CAB_IDX_RST = 12'h000;

  // opcode patterns
  localparam logic [5:0] CAB_ENC_ADDC = 6'h08;
  localparam logic [7:0] CAB_ENC_ANDL = 8'h0B;
  localparam logic [5:0] CAB_ENC_ANDF = 6'h05;
  localparam logic [7:0] CAB_ENC_BRC  = 8'hE2;
  localparam logic [3:0] CAB_ENC_BCLR = 4'h9;

  // addressing
  localparam logic [7:0]  CAB_IDX_LIMIT   = 8'h5F;
  localparam logic [7:0]  CAB_ACC_SPLIT   = 8'h60;
  localparam logic [3:0]  CAB_ACC_LO_BANK = 4'h0;
  localparam logic [3:0]  CAB_ACC_HI_BANK = 4'hF;
  localparam logic [20:0] CAB_PC_STEP     = 21'h000002;

  // phases of one instruction cycle, one clk each
  localparam logic [1:0] CAB_Q1 = 2'h0;
  localparam logic [1:0] CAB_Q2 = 2'h1;
  localparam logic [1:0] CAB_Q3 = 2'h2;
  localparam logic [1:0] CAB_Q4 = 2'h3;

  typedef enum logic [2:0] {
    CAB_OP_NOP,
    CAB_OP_ADD_WITH_CARRY_TO_FILE,
    CAB_OP_AND_LITERAL_INTO_WORKING,
    CAB_OP_AND_WORKING_WITH_FILE,
    CAB_OP_BRANCH_ON_CARRY_SET,
    CAB_OP_CLEAR_BIT_IN_FILE
  } cab_op_type;

  typedef struct packed {
    logic [1:0]  q;
    logic [20:0] pc;
    logic [7:0]  w;
    logic [4:0]  st;
    logic [3:0]  bank;
    logic        ext;
    logic [11:0] idx;
    cab_op_type  op;
    logic        d;
    logic [2:0]  bsel;
    logic [7:0]  lit;
    logic [7:0]  res;
    logic [4:0]  fl;
    logic        flush;
    logic        taken;
    logic        mrd;
    logic        mwr;
    logic [11:0] maddr;
    logic [7:0]  mwdata;
    logic [7:0]  rdat;
    logic        done;
    logic        illegal;
  } cab_state_type;

endpackage : cab_pkg
